// >>> rtc_timer_alarm_regs.svh
// Register offsets, field positions, reset values and timing counts of the RTC core.
// Assumes a 10 MHz system clock and byte addresses on an 8-bit AXI4-Lite address.
`ifndef RTC_TIMER_ALARM_REGS_SVH
`define RTC_TIMER_ALARM_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RTC_CTRL_OFS     8'h00
`define RTC_STATUS_OFS   8'h04
`define RTC_HOLD_OFS     8'h08
`define RTC_ALARM_OFS    8'h0C
`define RTC_ISTAT_OFS    8'h10
`define RTC_IMASK_OFS    8'h14
`define RTC_EVCFG_OFS    8'h18

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define RTC_CTRL_W       9
`define RTC_RUN_BIT      0
`define RTC_AUTORST_BIT  1
`define RTC_FAST_BIT     2
`define RTC_MISSING_CLOCK_ENABLE_BIT   3
`define RTC_SET_BIT      4
`define RTC_CAP_BIT      5
`define RTC_BIAS_DOUBLING_BIT   6
`define RTC_XTALEN_BIT   7
`define RTC_ALRMEN_BIT   8
`define RTC_CTRL_RST     9'h000

// ----------------------------------------------------------------------------
// Status, event and configuration fields
// ----------------------------------------------------------------------------
`define RTC_EV_W         2
`define RTC_EV_ALARM     0
`define RTC_EV_FAIL      1
`define RTC_ST_FAIL_BIT  0
`define RTC_ST_VALID_BIT 1
`define RTC_ST_MATCH_BIT 2
`define RTC_CFG_W        4
`define RTC_EV_RST       2'h0
`define RTC_CFG_RST      4'h0
`define RTC_WORD_RST     32'h0000_0000
`define RTC_RESP_OKAY    2'h0
`define RTC_RESP_SLVERR  2'h2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTC_CLK_PERIOD_NS 100
`define RTC_MCD_TIMEOUT_US 100
`define RTC_MCD_CYC ((`RTC_MCD_TIMEOUT_US * 1000 + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_MCD_W        11
`define RTC_BLANK_MS     2
`define RTC_BLANK_CYC ((`RTC_BLANK_MS * 1000000 + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)

`endif

// >>> rtc_timer_alarm_pkg.sv
// Types shared by the RTC core files.
// Assumes the constants of rtc_timer_alarm_regs.svh for widths.
`default_nettype none
package rtc_timer_alarm_pkg;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  resp_t;
  typedef enum {
    REG_CTRL, REG_STATUS, REG_HOLD, REG_ALARM, REG_ISTAT, REG_IMASK, REG_EVCFG, REG_NONE
  } reg_sel_t;
endpackage
`default_nettype wire

// >>> rtc_missing_clock.sv
// Missing-clock detector: flags a sampled oscillator level that stands too long.
// Assumes oscLevel is already registered in the ref_clk domain.
`include "rtc_timer_alarm_regs.svh"
`default_nettype none
module rtc_missing_clock (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic oscLevel,
  output var  logic failPulse
);
  logic [`RTC_MCD_W-1:0] cnt_ff;
  logic [`RTC_MCD_W-1:0] nxt_cnt;
  logic                  last_ff;
  logic                  nxt_last;
  logic                  fired_ff;
  logic                  nxt_fired;
  logic                  pulse_ff;
  logic                  nxt_pulse;

  // Counts cycles since the last level change and fires once per stuck period.
  always_comb begin
    nxt_last  = oscLevel;
    nxt_cnt   = cnt_ff;
    nxt_fired = fired_ff;
    nxt_pulse = 1'b0;
    if (!enable || oscLevel != last_ff) begin
      nxt_cnt   = '0;
      nxt_fired = 1'b0;
    end else if (!fired_ff) begin
      if (cnt_ff == `RTC_MCD_W'(`RTC_MCD_CYC)) begin
        nxt_pulse = 1'b1;
        nxt_fired = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + `RTC_MCD_W'(1);
      end
    end
  end

  // Registers the detector state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_ff   <= '0;
      last_ff  <= 1'b0;
      fired_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      last_ff  <= nxt_last;
      fired_ff <= nxt_fired;
      pulse_ff <= nxt_pulse;
    end
  end

  assign failPulse = pulse_ff;
endmodule
`default_nettype wire

// >>> rtc_timer_alarm.sv
// RTC timer core with alarm, auto reset, set/capture transfers, missing-clock
// detector and crystal-valid status, reached over an AXI4-Lite slave.
// Assumes rtcOsc and ampDetect are synchronous to ref_clk and slower than it.
//
// Operation
// - 32-bit counter steps once per oscillator cycle while timer_run is set.
// - Alarm match can raise interrupt, wake request or chip reset request.
// - With auto reset, counter clears one oscillator cycle after match ends.
// - Counter may be set or read while it keeps running.
// - Set request copies holding register into counter, then clears itself.
// - Capture request snapshots counter into holding register, then clears itself.
// - Enabled detector flags oscillator stuck high or low beyond 100 us.
// - Missing clock can raise interrupt, wake request or chip reset request.
// - crystal_valid reads invalid during 2 ms blanking after oscillator start.
// - crystal_valid is forced low while bias_doubling is off.
`include "rtc_timer_alarm_regs.svh"
`default_nettype none
module rtc_timer_alarm #(
  parameter int BLANK_CYCLES = `RTC_BLANK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        rtcOsc,
  input  wire logic        ampDetect,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic        irq,
  output var  logic        wakeReq,
  output var  logic        chipResetReq
);
  // ----------------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------------
  // Maps a byte address onto a register selector.
  function automatic rtc_timer_alarm_pkg::reg_sel_t decodeAddr(input logic [7:0] a);
    case (a)
      `RTC_CTRL_OFS:   decodeAddr = rtc_timer_alarm_pkg::REG_CTRL;
      `RTC_STATUS_OFS: decodeAddr = rtc_timer_alarm_pkg::REG_STATUS;
      `RTC_HOLD_OFS:   decodeAddr = rtc_timer_alarm_pkg::REG_HOLD;
      `RTC_ALARM_OFS:  decodeAddr = rtc_timer_alarm_pkg::REG_ALARM;
      `RTC_ISTAT_OFS:  decodeAddr = rtc_timer_alarm_pkg::REG_ISTAT;
      `RTC_IMASK_OFS:  decodeAddr = rtc_timer_alarm_pkg::REG_IMASK;
      `RTC_EVCFG_OFS:  decodeAddr = rtc_timer_alarm_pkg::REG_EVCFG;
      default:         decodeAddr = rtc_timer_alarm_pkg::REG_NONE;
    endcase
  endfunction

  // Merges write data into an old value under the byte strobes.
  function automatic rtc_timer_alarm_pkg::word_t mergeStrb(
    input rtc_timer_alarm_pkg::word_t oldVal,
    input rtc_timer_alarm_pkg::word_t newVal,
    input logic [3:0]                 strb
  );
    mergeStrb = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        mergeStrb[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  logic [7:0]                 awAddr_ff, nxt_awAddr;
  logic                       awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
  rtc_timer_alarm_pkg::word_t wData_ff, nxt_wData;
  logic [3:0]                 wStrb_ff, nxt_wStrb;
  logic                       awReady_ff, nxt_awReady, wReady_ff, nxt_wReady;
  logic                       bValid_ff, nxt_bValid, arReady_ff, nxt_arReady;
  logic                       rValid_ff, nxt_rValid;
  rtc_timer_alarm_pkg::resp_t bResp_ff, nxt_bResp, rResp_ff, nxt_rResp;
  rtc_timer_alarm_pkg::word_t rData_ff, nxt_rData;
  logic                       doWrite;
  rtc_timer_alarm_pkg::reg_sel_t wSel;
  rtc_timer_alarm_pkg::reg_sel_t rSel;

  logic [`RTC_CTRL_W-1:0]     ctrl_ff, nxt_ctrl;
  logic                       setReq_ff, nxt_setReq, capReq_ff, nxt_capReq;
  rtc_timer_alarm_pkg::word_t cnt_ff, nxt_cnt, hold_ff, nxt_hold, alarm_ff, nxt_alarm;
  logic                       resetPend_ff, nxt_resetPend, matchQ_ff, nxt_matchQ;
  logic                       rtcQ_ff, nxt_rtcQ;
  logic [`RTC_EV_W-1:0]       iStat_ff, nxt_iStat, iMask_ff, nxt_iMask;
  logic [`RTC_CFG_W-1:0]      evCfg_ff, nxt_evCfg;
  rtc_timer_alarm_pkg::word_t blank_ff, nxt_blank;
  logic                       xtalValid_ff, nxt_xtalValid;
  logic                       irq_ff, nxt_irq, wake_ff, nxt_wake, chipRst_ff, nxt_chipRst;
  logic [`RTC_CTRL_W-1:0]     ctrlView;
  logic                       rtcTick, xferNow, match, failPulse;
  logic [`RTC_EV_W-1:0]       events, clr;
  rtc_timer_alarm_pkg::word_t merged, ctrlMerged;

  assign ctrlMerged   = mergeStrb(32'(ctrlView), wData_ff, wStrb_ff);
  assign doWrite      = awHeld_ff && wHeld_ff && !bValid_ff;
  assign wSel         = decodeAddr(awAddr_ff);
  assign rSel         = decodeAddr(s_axi_araddr);

  // Control view with the live transfer request bits.
  always_comb begin
    ctrlView                = ctrl_ff;
    ctrlView[`RTC_SET_BIT]  = setReq_ff;
    ctrlView[`RTC_CAP_BIT]  = capReq_ff;
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite handshake and read mux
  // ----------------------------------------------------------------------------
  // Address and data are taken in either order; the response follows both.
  always_comb begin
    nxt_awAddr  = awAddr_ff;
    nxt_awHeld  = awHeld_ff;
    nxt_wHeld   = wHeld_ff;
    nxt_wData   = wData_ff;
    nxt_wStrb   = wStrb_ff;
    nxt_bValid  = bValid_ff;
    nxt_bResp   = bResp_ff;
    nxt_rValid  = rValid_ff;
    nxt_rResp   = rResp_ff;
    nxt_rData   = rData_ff;
    if (s_axi_awvalid && awReady_ff) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_ff) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld  = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp  = (wSel == rtc_timer_alarm_pkg::REG_NONE ||
                    wSel == rtc_timer_alarm_pkg::REG_STATUS) ?
                   `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
    end else if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (s_axi_arvalid && arReady_ff) begin
      nxt_rValid = 1'b1;
      nxt_rResp  = `RTC_RESP_OKAY;
      nxt_rData  = `RTC_WORD_RST;
      case (rSel)
        rtc_timer_alarm_pkg::REG_CTRL:   nxt_rData[`RTC_CTRL_W-1:0] = ctrlView;
        rtc_timer_alarm_pkg::REG_STATUS: begin
          nxt_rData[`RTC_ST_FAIL_BIT]  = iStat_ff[`RTC_EV_FAIL];
          nxt_rData[`RTC_ST_VALID_BIT] = xtalValid_ff;
          nxt_rData[`RTC_ST_MATCH_BIT] = matchQ_ff;
        end
        rtc_timer_alarm_pkg::REG_HOLD:   nxt_rData = hold_ff;
        rtc_timer_alarm_pkg::REG_ALARM:  nxt_rData = alarm_ff;
        rtc_timer_alarm_pkg::REG_ISTAT:  nxt_rData[`RTC_EV_W-1:0] = iStat_ff;
        rtc_timer_alarm_pkg::REG_IMASK:  nxt_rData[`RTC_EV_W-1:0] = iMask_ff;
        rtc_timer_alarm_pkg::REG_EVCFG:  nxt_rData[`RTC_CFG_W-1:0] = evCfg_ff;
        default:                         nxt_rResp = `RTC_RESP_SLVERR;
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
    nxt_awReady = !nxt_awHeld && !nxt_bValid;
    nxt_wReady  = !nxt_wHeld && !nxt_bValid;
    nxt_arReady = !nxt_rValid;
  end

  // Registers the bus handshake state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awAddr_ff  <= 8'h00;
      awHeld_ff  <= 1'b0;
      wHeld_ff   <= 1'b0;
      wData_ff   <= `RTC_WORD_RST;
      wStrb_ff   <= 4'h0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= `RTC_RESP_OKAY;
      rValid_ff  <= 1'b0;
      rResp_ff   <= `RTC_RESP_OKAY;
      rData_ff   <= `RTC_WORD_RST;
      awReady_ff <= 1'b0;
      wReady_ff  <= 1'b0;
      arReady_ff <= 1'b0;
    end else begin
      awAddr_ff  <= nxt_awAddr;
      awHeld_ff  <= nxt_awHeld;
      wHeld_ff   <= nxt_wHeld;
      wData_ff   <= nxt_wData;
      wStrb_ff   <= nxt_wStrb;
      bValid_ff  <= nxt_bValid;
      bResp_ff   <= nxt_bResp;
      rValid_ff  <= nxt_rValid;
      rResp_ff   <= nxt_rResp;
      rData_ff   <= nxt_rData;
      awReady_ff <= nxt_awReady;
      wReady_ff  <= nxt_wReady;
      arReady_ff <= nxt_arReady;
    end
  end

  // ----------------------------------------------------------------------------
  // Timer, transfers, events and interrupt logic
  // ----------------------------------------------------------------------------
  rtc_missing_clock u_mcd (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .enable    (ctrl_ff[`RTC_MISSING_CLOCK_ENABLE_BIT]),
    .oscLevel  (rtcQ_ff),
    .failPulse (failPulse)
  );

  assign rtcTick = rtcOsc && !rtcQ_ff; // One ref_clk cycle per oscillator cycle.
  assign xferNow = ctrl_ff[`RTC_FAST_BIT] ? 1'b1 : rtcTick; // Fast mode uses system clock.
  assign match   = ctrl_ff[`RTC_ALRMEN_BIT] && (cnt_ff == alarm_ff);
  assign merged  = mergeStrb(`RTC_WORD_RST, wData_ff, wStrb_ff);

  // Computes the next timer and register state; hardware sets win over clears.
  always_comb begin
    nxt_ctrl      = ctrl_ff;
    nxt_setReq    = setReq_ff;
    nxt_capReq    = capReq_ff;
    nxt_cnt       = cnt_ff;
    nxt_hold      = hold_ff;
    nxt_alarm     = alarm_ff;
    nxt_resetPend = resetPend_ff;
    nxt_matchQ    = match;
    nxt_rtcQ      = rtcOsc;
    nxt_iMask     = iMask_ff;
    nxt_evCfg     = evCfg_ff;
    nxt_blank     = blank_ff;
    clr           = '0;
    if (doWrite) begin
      case (wSel)
        rtc_timer_alarm_pkg::REG_CTRL: begin
          nxt_ctrl = ctrlMerged[`RTC_CTRL_W-1:0];
          if (nxt_ctrl[`RTC_SET_BIT]) nxt_setReq = 1'b1;
          if (nxt_ctrl[`RTC_CAP_BIT]) nxt_capReq = 1'b1;
          nxt_ctrl[`RTC_SET_BIT] = 1'b0;
          nxt_ctrl[`RTC_CAP_BIT] = 1'b0;
        end
        rtc_timer_alarm_pkg::REG_HOLD:  nxt_hold  = mergeStrb(hold_ff, wData_ff, wStrb_ff);
        rtc_timer_alarm_pkg::REG_ALARM: nxt_alarm = mergeStrb(alarm_ff, wData_ff, wStrb_ff);
        rtc_timer_alarm_pkg::REG_ISTAT: clr       = merged[`RTC_EV_W-1:0];
        rtc_timer_alarm_pkg::REG_IMASK: nxt_iMask = merged[`RTC_EV_W-1:0];
        rtc_timer_alarm_pkg::REG_EVCFG: nxt_evCfg = merged[`RTC_CFG_W-1:0];
        default: ;
      endcase
    end
    // Counting: a pending auto reset replaces one increment with a clear.
    if (rtcTick && ctrl_ff[`RTC_RUN_BIT]) begin
      if (resetPend_ff) begin
        nxt_cnt       = `RTC_WORD_RST;
        nxt_resetPend = 1'b0;
      end else begin
        nxt_cnt       = cnt_ff + 32'h0000_0001;
        nxt_resetPend = ctrl_ff[`RTC_AUTORST_BIT] && match;
      end
    end
    // Transfers run beside counting, so the counter never has to stop.
    if (setReq_ff && xferNow) begin
      nxt_cnt       = hold_ff;
      nxt_resetPend = 1'b0;
      nxt_setReq    = 1'b0;
    end
    if (capReq_ff && xferNow) begin
      nxt_hold   = cnt_ff;
      nxt_capReq = 1'b0;
    end
    // Blanking restarts whenever the crystal oscillator is off.
    if (!ctrl_ff[`RTC_XTALEN_BIT]) begin
      nxt_blank = `RTC_WORD_RST;
    end else if (blank_ff != 32'(BLANK_CYCLES)) begin
      nxt_blank = blank_ff + 32'h0000_0001;
    end
    nxt_xtalValid = ctrl_ff[`RTC_BIAS_DOUBLING_BIT] && ctrl_ff[`RTC_XTALEN_BIT] &&
                    (blank_ff == 32'(BLANK_CYCLES)) && ampDetect;
    events                = '0;
    events[`RTC_EV_ALARM] = match && !matchQ_ff;
    events[`RTC_EV_FAIL]  = failPulse;
    nxt_iStat   = (iStat_ff & ~clr) | events;
    nxt_irq     = |(nxt_iStat & iMask_ff);
    nxt_wake    = |(nxt_iStat & evCfg_ff[`RTC_EV_W-1:0]);
    nxt_chipRst = |(events & evCfg_ff[`RTC_CFG_W-1:`RTC_EV_W]);
  end

  // Registers the timer and register state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_ff      <= `RTC_CTRL_RST;
      setReq_ff    <= 1'b0;
      capReq_ff    <= 1'b0;
      cnt_ff       <= `RTC_WORD_RST;
      hold_ff      <= `RTC_WORD_RST;
      alarm_ff     <= `RTC_WORD_RST;
      resetPend_ff <= 1'b0;
      matchQ_ff    <= 1'b0;
      rtcQ_ff      <= 1'b0;
      iStat_ff     <= `RTC_EV_RST;
      iMask_ff     <= `RTC_EV_RST;
      evCfg_ff     <= `RTC_CFG_RST;
      blank_ff     <= `RTC_WORD_RST;
      xtalValid_ff <= 1'b0;
      irq_ff       <= 1'b0;
      wake_ff      <= 1'b0;
      chipRst_ff   <= 1'b0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      setReq_ff    <= nxt_setReq;
      capReq_ff    <= nxt_capReq;
      cnt_ff       <= nxt_cnt;
      hold_ff      <= nxt_hold;
      alarm_ff     <= nxt_alarm;
      resetPend_ff <= nxt_resetPend;
      matchQ_ff    <= nxt_matchQ;
      rtcQ_ff      <= nxt_rtcQ;
      iStat_ff     <= nxt_iStat;
      iMask_ff     <= nxt_iMask;
      evCfg_ff     <= nxt_evCfg;
      blank_ff     <= nxt_blank;
      xtalValid_ff <= nxt_xtalValid;
      irq_ff       <= nxt_irq;
      wake_ff      <= nxt_wake;
      chipRst_ff   <= nxt_chipRst;
    end
  end

  // Output ports straight from flip-flops.
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready  = wReady_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign irq           = irq_ff;
  assign wakeReq       = wake_ff;
  assign chipResetReq  = chipRst_ff;
endmodule
`default_nettype wire

// >>> rtc_timer_alarm_checker.sv
// Checker of the bus handshakes of the RTC core.
// Assumes it is bound to rtc_timer_alarm and sees ports of the same names.
`default_nettype none
module rtc_timer_alarm_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ----
  // Handshakes
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A whole write taken at one edge, and a read address taken.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data missing");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule
bind rtc_timer_alarm rtc_timer_alarm_checker rtc_timer_alarm_checker_i (.*);
`default_nettype wire

// >>> rtc_timer_alarm_tb.sv
// Self-checking bench of the RTC core over its register bus.
// Assumes the core, its header, package and checker are compiled before it.
`include "rtc_timer_alarm_regs.svh"
`default_nettype none
module rtc_timer_alarm_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLANK = 50;
  logic        ref_clk = 1'h0, rst_n = 1'h0, rtcOsc = 1'h0, ampDetect = 1'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ctrl, v, a;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq, wakeReq, chipResetReq;
  int          n_mismatch = 0, checks_done = 0, nRst = 0, n, i, half = 3;
  rtc_timer_alarm #(.BLANK_CYCLES(BLANK)) rtc_timer_alarm_i (.*);
  // ----
  // Clock, pulse count and tasks
  // ----
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (chipResetReq === 1'h1) nRst <= nRst + 1;
  // Compares a value and counts the result.
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  // A wait that ran out ends the run.
  task automatic tmo(input int c);
    if (c >= 50) begin
      check("bus wait", 32'h0, 32'h1);
      summarize();
    end
  endtask
  // Bus write: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                    input logic [1:0] er = `RTC_RESP_OKAY);
    logic aw, w;
    int   c;
    aw = 1'h0;
    w = 1'h0;
    c = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w) && c < 50) begin
      @(posedge ref_clk);
      c++;
      aw = aw || s_axi_awready === 1'h1;
      w = w || s_axi_wready === 1'h1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    tmo(c);
    repeat ($urandom_range(2)) @(posedge ref_clk);
    s_axi_bready <= 1'h1;
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (s_axi_bvalid !== 1'h1 && c < 50);
    s_axi_bready <= 1'h0;
    tmo(c);
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  // Bus read: address held until taken, data taken at the handshake edge.
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    int c;
    c = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      c++;
    end while (s_axi_arready !== 1'h1 && c < 50);
    s_axi_arvalid <= 1'h0;
    tmo(c);
    repeat ($urandom_range(2)) @(posedge ref_clk);
    s_axi_rready <= 1'h1;
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (s_axi_rvalid !== 1'h1 && c < 50);
    s_axi_rready <= 1'h0;
    tmo(c);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Bus read with a masked comparison of data and response.
  task automatic rdChk(input string w, input logic [7:0] ad, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFF_FFFF,
                       input logic [1:0] er = `RTC_RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ad, d, r);
    check({w, " resp"}, {30'h0, er}, {30'h0, r});
    check(w, e & m, d & m);
  endtask
  // Polls a control request bit until the core clears it, bounded.
  task automatic waitClr(input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    k = 0;
    do begin
      rd(`RTC_CTRL_OFS, d, r);
      k++;
    end while ((d & m) !== 32'h0 && k < 20);
    check("request clear", 32'h0, d & m);
  endtask
  // Oscillator cycles of half reference cycles high and as many low.
  task automatic tick(input int c);
    repeat (c) begin
      rtcOsc <= 1'h1;
      repeat (half) @(posedge ref_clk);
      rtcOsc <= 1'h0;
      repeat (half) @(posedge ref_clk);
    end
  endtask
  // Fast set and fast capture of the counter.
  task automatic setCnt(input logic [31:0] val);
    wr(`RTC_HOLD_OFS, val);
    wr(`RTC_CTRL_OFS, ctrl | 32'h10);
    waitClr(32'h10);
  endtask
  task automatic capChk(input logic [31:0] e);
    wr(`RTC_CTRL_OFS, ctrl | 32'h20);
    waitClr(32'h20);
    rdChk("captured count", `RTC_HOLD_OFS, e);
  endtask
  function automatic logic [31:0] expCnt(input logic [31:0] s, input int t);
    return s + 32'(t);
  endfunction
  task automatic summarize();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(20));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rdChk("ctrl reset", `RTC_CTRL_OFS, 32'h0);
    rdChk("unmapped", 8'h1C, 32'h0, 32'hFFFF_FFFF, `RTC_RESP_SLVERR);
    wr(`RTC_STATUS_OFS, 32'hFFFF_FFFF, `RTC_RESP_SLVERR);
    ctrl = 32'h5;
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hFFFF_FFFE : $urandom;
      n = (i == 0) ? 3 : $urandom_range(6, 1);
      setCnt(v);
      tick(n);
      capChk(expCnt(v, n));
    end
    ctrl = 32'h1;
    half = 1;
    wr(`RTC_HOLD_OFS, 32'h10);
    wr(`RTC_CTRL_OFS, ctrl | 32'h10);
    rdChk("set pending", `RTC_CTRL_OFS, 32'h10, 32'h10);
    tick(1);
    rdChk("set done", `RTC_CTRL_OFS, 32'h0, 32'h10);
    wr(`RTC_CTRL_OFS, ctrl | 32'h20);
    tick(1);
    rdChk("slow capture", `RTC_HOLD_OFS, 32'h10);
    half = 3;
    a = $urandom_range(32'h0FFF_FFFF, 32'h100);
    ctrl = 32'h105;
    wr(`RTC_ALARM_OFS, a);
    wr(`RTC_IMASK_OFS, 32'h1);
    wr(`RTC_EVCFG_OFS, 32'h5);
    setCnt(a - 32'h2);
    n = nRst;
    tick(1);
    rdChk("alarm early", `RTC_ISTAT_OFS, 32'h0, 32'h1);
    tick(1);
    repeat (3) @(posedge ref_clk);
    check("irq wake reset", 32'h7, {29'h0, irq, wakeReq, nRst == n + 1});
    wr(`RTC_IMASK_OFS, 32'h0);
    @(posedge ref_clk);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(`RTC_ISTAT_OFS, 32'h1);
    rdChk("alarm cleared", `RTC_ISTAT_OFS, 32'h0, 32'h1);
    ctrl = 32'h107;
    setCnt(a - 32'h2);
    tick(3);
    capChk(a + 32'h1);
    tick(1);
    capChk(32'h0);
    wr(`RTC_ISTAT_OFS, 32'h3);
    wr(`RTC_IMASK_OFS, 32'h2);
    wr(`RTC_EVCFG_OFS, 32'h8);
    n = nRst;
    ctrl = 32'h8;
    wr(`RTC_CTRL_OFS, ctrl);
    repeat (900) @(posedge ref_clk);
    rdChk("fail early", `RTC_ISTAT_OFS, 32'h0, 32'h2);
    repeat (200) @(posedge ref_clk);
    rdChk("fail flag", `RTC_STATUS_OFS, 32'h1, 32'h1);
    check("fail irq reset", 32'h3, {30'h0, irq, nRst == n + 1});
    wr(`RTC_CTRL_OFS, 32'h0);
    wr(`RTC_CTRL_OFS, 32'h80);
    repeat (BLANK + 20) @(posedge ref_clk);
    rdChk("valid no bias", `RTC_STATUS_OFS, 32'h0, 32'h2);
    wr(`RTC_CTRL_OFS, 32'hC0);
    rdChk("valid", `RTC_STATUS_OFS, 32'h2, 32'h2);
    ampDetect <= 1'h0;
    @(posedge ref_clk);
    rdChk("valid no amp", `RTC_STATUS_OFS, 32'h0, 32'h2);
    ampDetect <= 1'h1;
    wr(`RTC_CTRL_OFS, 32'h0);
    wr(`RTC_CTRL_OFS, 32'hC0);
    rdChk("valid blanked", `RTC_STATUS_OFS, 32'h0, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire
